// ---- design/sector_flash_host.v ----
// host controller driving a 256K x 8 sector flash on its parallel pins
// assumes one 50 MHz clock; flash pins need not share it, data pins are synchronised
`default_nettype none
`include "sector_flash_host_defines.vh"
module sector_flash_host #(
   parameter GUARD_ADDR0 = 18'h0_5555,
   parameter GUARD_ADDR1 = 18'h0_2AAA,
   parameter GUARD_ADDR2 = 18'h0_5555,
   parameter GUARD_DATA0 = 8'hAA,
   parameter GUARD_DATA1 = 8'h55,
   parameter GUARD_DATA2 = 8'hA0,
   parameter POWER_ON_CYC = `POWER_ON_CYC,
   parameter CYCLE_CYC = `SECTOR_CYCLE_CYC
) (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // user command port
   input wire rd_req,
   input wire prog_req,
   input wire guard_on,
   input wire [17:0] user_addr,
   input wire [`SECTOR_ADDR_W-1:0] sector_addr,
   input wire [7:0] fill_data,
   output reg busy_ff,
   output reg done_ff,
   output reg timeout_ff,
   output reg [7:0] rd_data_ff,
   // sector data source, one byte per offset
   output reg [`BYTE_ADDR_W-1:0] fill_idx_ff,
   // flash pins
   output reg [17:0] fl_addr_ff,
   output reg fl_ce_n_ff,
   output reg fl_oe_n_ff,
   output reg fl_we_n_ff,
   input wire [7:0] fl_dq_in,
   output reg [7:0] fl_dq_out_ff,
   output reg fl_dq_oe_ff
);
   // ****************************************************
   // state machine
   // ****************************************************
   localparam [8:0] ST_PWR = 9'h001;
   localparam [8:0] ST_IDLE = 9'h002;
   localparam [8:0] ST_RD = 9'h004;
   localparam [8:0] ST_LSET = 9'h008;
   localparam [8:0] ST_LLOW = 9'h010;
   localparam [8:0] ST_LHIGH = 9'h020;
   localparam [8:0] ST_GAP = 9'h040;
   localparam [8:0] ST_POLL = 9'h080;
   localparam [8:0] ST_PGAP = 9'h100;

   reg [8:0] state_ff;
   reg [23:0] cnt_ff;
   reg [23:0] cyc_ff;
   reg [1:0] cmd_ff;
   reg in_cmd_ff;
   reg [7:0] last_ff;
   reg [7:0] dq_s1_ff;
   reg [7:0] dq_s2_ff;

   // data pins come from the flash's own timing domain
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dq_s1_ff <= 8'h00;
         dq_s2_ff <= 8'h00;
      end else begin
         dq_s1_ff <= fl_dq_in;
         dq_s2_ff <= dq_s1_ff;
      end
   end

   // ****************************************************
   // sequencer
   // ****************************************************
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= ST_PWR;
         cnt_ff <= 24'h00_0000;
         cyc_ff <= 24'h00_0000;
         cmd_ff <= 2'h0;
         in_cmd_ff <= 1'b0;
         last_ff <= 8'h00;
         busy_ff <= 1'b1;
         done_ff <= 1'b0;
         timeout_ff <= 1'b0;
         rd_data_ff <= 8'h00;
         fill_idx_ff <= 8'h00;
         fl_addr_ff <= 18'h0_0000;
         fl_ce_n_ff <= 1'b1;
         fl_oe_n_ff <= 1'b1;
         fl_we_n_ff <= 1'b1;
         fl_dq_out_ff <= 8'h00;
         fl_dq_oe_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         cnt_ff <= cnt_ff + 24'h00_0001;
         case (state_ff)
            ST_PWR: begin
               // hold off programming until the flash's power on delay is over
               if ({8'h00, cnt_ff} >= POWER_ON_CYC) begin
                  state_ff <= ST_IDLE;
                  busy_ff <= 1'b0;
               end
            end
            ST_IDLE: begin
               cnt_ff <= 24'h00_0000;
               fl_oe_n_ff <= 1'b1;
               fl_ce_n_ff <= 1'b1;
               if (rd_req) begin
                  busy_ff <= 1'b1;
                  fl_addr_ff <= user_addr;
                  fl_ce_n_ff <= 1'b0;
                  fl_oe_n_ff <= 1'b0;
                  state_ff <= ST_RD;
               end else if (prog_req) begin
                  busy_ff <= 1'b1;
                  timeout_ff <= 1'b0;
                  in_cmd_ff <= guard_on;
                  cmd_ff <= 2'h0;
                  fill_idx_ff <= 8'h00;
                  state_ff <= ST_LSET;
               end
            end
            ST_RD: begin
               if (cnt_ff == `READ_WAIT_CYC) begin
                  rd_data_ff <= dq_s2_ff;
                  fl_ce_n_ff <= 1'b1;
                  fl_oe_n_ff <= 1'b1;
                  busy_ff <= 1'b0;
                  done_ff <= 1'b1;
                  state_ff <= ST_IDLE;
               end
            end
            ST_LSET: begin
               // drive address and data before the falling strobe edge
               if (in_cmd_ff) begin
                  case (cmd_ff)
                     2'h0: begin
                        fl_addr_ff <= GUARD_ADDR0;
                        fl_dq_out_ff <= GUARD_DATA0;
                     end
                     2'h1: begin
                        fl_addr_ff <= GUARD_ADDR1;
                        fl_dq_out_ff <= GUARD_DATA1;
                     end
                     default: begin
                        fl_addr_ff <= GUARD_ADDR2;
                        fl_dq_out_ff <= GUARD_DATA2;
                     end
                  endcase
               end else begin
                  fl_addr_ff <= {sector_addr, fill_idx_ff};
                  fl_dq_out_ff <= fill_data;
                  last_ff <= fill_data;
               end
               fl_dq_oe_ff <= 1'b1;
               fl_oe_n_ff <= 1'b1;
               fl_ce_n_ff <= 1'b0;
               cnt_ff <= 24'h00_0000;
               state_ff <= ST_LLOW;
            end
            ST_LLOW: begin
               fl_we_n_ff <= 1'b0;
               if (cnt_ff == `STROBE_LOW_CYC) begin
                  fl_we_n_ff <= 1'b1;
                  cnt_ff <= 24'h00_0000;
                  state_ff <= ST_LHIGH;
               end
            end
            ST_LHIGH: begin
               if (cnt_ff == `STROBE_SETUP_CYC) begin
                  fl_ce_n_ff <= 1'b1;
                  fl_dq_oe_ff <= 1'b0;
                  if (in_cmd_ff) begin
                     cmd_ff <= cmd_ff + 2'h1;
                     if (cmd_ff == 2'h2) begin
                        in_cmd_ff <= 1'b0;
                     end
                     state_ff <= ST_LSET;
                  end else if (fill_idx_ff == 8'hFF) begin
                     // whole sector loaded; flash programs after its load gap
                     cnt_ff <= 24'h00_0000;
                     state_ff <= ST_GAP;
                  end else begin
                     fill_idx_ff <= fill_idx_ff + 8'h01;
                     state_ff <= ST_LSET;
                  end
               end
            end
            ST_GAP: begin
               // wait out the load window so programming begins, no strobes meanwhile
               if (cnt_ff >= `LOAD_END_CYC) begin
                  cyc_ff <= 24'h00_0000;
                  cnt_ff <= 24'h00_0000;
                  fl_addr_ff <= {sector_addr, 8'hFF};
                  state_ff <= ST_POLL;
               end
            end
            ST_POLL: begin
               cyc_ff <= cyc_ff + 24'h00_0001;
               fl_ce_n_ff <= 1'b0;
               fl_oe_n_ff <= 1'b0;
               if (cnt_ff == `READ_WAIT_CYC) begin
                  fl_ce_n_ff <= 1'b1;
                  fl_oe_n_ff <= 1'b1;
                  cnt_ff <= 24'h00_0000;
                  if (dq_s2_ff[`POLL_BIT] == last_ff[`POLL_BIT]) begin
                     busy_ff <= 1'b0;
                     done_ff <= 1'b1;
                     state_ff <= ST_IDLE;
                  end else if ({8'h00, cyc_ff} >= CYCLE_CYC) begin
                     timeout_ff <= 1'b1;
                     busy_ff <= 1'b0;
                     done_ff <= 1'b1;
                     state_ff <= ST_IDLE;
                  end else begin
                     state_ff <= ST_PGAP;
                  end
               end
            end
            ST_PGAP: begin
               cyc_ff <= cyc_ff + 24'h00_0001;
               if (cnt_ff == `READ_WAIT_CYC) begin
                  cnt_ff <= 24'h00_0000;
                  state_ff <= ST_POLL;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // sector_flash_host
`default_nettype wire

// ---- design/sector_flash_host_defines.vh ----
// constants for the parallel sector flash host controller
// assumes a 50 MHz system clock
`ifndef SECTOR_FLASH_HOST_DEFINES_VH
`define SECTOR_FLASH_HOST_DEFINES_VH
`define CLK_PERIOD_NS 20
`define LOAD_GAP_US 150
// longest gap, rounded down, with margin: 100 us used as target
`define LOAD_GAP_SAFE_US 100
`define LOAD_GAP_CYC ((`LOAD_GAP_SAFE_US * 1000) / `CLK_PERIOD_NS)
`define SECTOR_CYCLE_MS 10
`define SECTOR_CYCLE_CYC ((`SECTOR_CYCLE_MS * 1000000) / `CLK_PERIOD_NS)
`define POWER_ON_MS 5
`define POWER_ON_CYC ((`POWER_ON_MS * 1000000) / `CLK_PERIOD_NS)
// quiet time after the last byte so the flash closes its load window: 160 us at 20 ns
`define LOAD_END_CYC 24'h00_1F40
// strobe low time, comfortably above the 15 ns noise filter
`define STROBE_LOW_CYC 24'h00_0004
`define STROBE_SETUP_CYC 24'h00_0001
`define READ_WAIT_CYC 24'h00_0005
`define SECTOR_BYTES 256
`define BYTE_ADDR_W 8
`define SECTOR_ADDR_W 10
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define GUARD_CMD_COUNT 3
`endif

// ---- sim/flash_host_sva.sv ----
// pin checker for the sector flash host
// bound into sector_flash_host, sees its ports only
`default_nettype none
module flash_host_sva (
   // clock, reset, user side
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic rd_req,
   input wire logic busy_ff,
   input wire logic done_ff,
   // flash pins
   input wire logic [17:0] fl_addr_ff,
   input wire logic fl_ce_n_ff,
   input wire logic fl_oe_n_ff,
   input wire logic fl_we_n_ff,
   input wire logic [7:0] fl_dq_out_ff,
   input wire logic fl_dq_oe_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_load; !fl_ce_n_ff && fl_oe_n_ff && fl_dq_oe_ff; endsequence
   sequence s_read; !fl_ce_n_ff && !fl_oe_n_ff; endsequence
   AST_NO_FIGHT: assert property (s_read |-> fl_we_n_ff && !fl_dq_oe_ff)
      else $error("read contention");
   AST_LOAD: assert property (!fl_we_n_ff |-> s_load)
      else $error("bad load strobe");
   AST_HOLD: assert property (!fl_we_n_ff && !$past(fl_we_n_ff) |-> $stable(fl_addr_ff) && $stable(fl_dq_out_ff))
      else $error("load moved");
   AST_WIDTH: assert property ($fell(fl_we_n_ff) |-> !fl_we_n_ff [*4])
      else $error("short strobe");
   AST_RISE: assert property ($rose(fl_we_n_ff) |-> !fl_ce_n_ff ##1 !fl_ce_n_ff)
      else $error("select rose first");
   AST_READ7: assert property (rd_req && !busy_ff && !done_ff |-> ##7 done_ff)
      else $error("read late");
   AST_DONE: assert property (done_ff |-> !busy_ff ##1 !done_ff)
      else $error("done not a pulse");
   AST_IDLE: assert property (!busy_ff |-> fl_we_n_ff && !fl_dq_oe_ff)
      else $error("idle strobe");
endmodule // flash_host_sva
bind sector_flash_host flash_host_sva u_sva (.clk, .sys_rst, .rd_req, .busy_ff, .done_ff, .fl_addr_ff,
   .fl_ce_n_ff, .fl_oe_n_ff, .fl_we_n_ff, .fl_dq_out_ff, .fl_dq_oe_ff);
`default_nettype wire

// ---- sim/flash_model.sv ----
// behavioural sector flash seen from its pins
// dq_rd is what the flash puts on the data wires
`default_nettype none
module flash_model (
   // strobes
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   // address and data
   input wire logic [17:0] addr,
   input wire logic [7:0] dq_wr,
   output logic [7:0] dq_rd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:262143];
   logic [17:0] qa [$];
   logic [7:0] qd [$];
   logic [17:0] a_lat;
   logic [7:0] last_d = 0, held = 0;
   logic prog = 0, tog = 0, guard = 0, hit;
   realtime t_fall = 0, t_rise = 0, prog_ns = 1000;
   wire logic load = oe_n && !prog;
   wire logic rdy = !ce_n && !oe_n && we_n;
   wire logic [7:0] rd = prog ? {~last_d[7], tog, last_d[5:0]} : mem[addr];
   initial foreach (mem[i]) mem[i] = 8'hff;
   always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n && load) begin
      a_lat = addr;
      t_fall = $realtime;
   end
   always @(posedge we_n or posedge ce_n) if ((we_n ^ ce_n) && load && $realtime - t_fall >= 15) begin
      qa.push_back(a_lat);
      qd.push_back(dq_wr);
      last_d = dq_wr;
      t_rise = $realtime;
   end
   initial forever begin
      #1000;
      if (qa.size() != 0 && !prog && $realtime - t_rise > 150000) begin
         hit = qa.size() > 2 && {qa[0], qd[0], qa[1], qd[1], qa[2], qd[2]} ===
            {18'h0_5555, 8'haa, 18'h0_2aaa, 8'h55, 18'h0_5555, 8'ha0};
         guard = guard | hit;
         prog = 1;
         #(prog_ns);
         if (hit || !guard) begin
            for (int j = 0; j < 256; j++) mem[{qa[$][17:8], j[7:0]}] = 8'hxx;
            for (int j = hit ? 3 : 0; j < qa.size(); j++) mem[qa[j]] = qd[j];
         end
         prog = 0;
         qa.delete();
         qd.delete();
      end
   end
   always @(negedge oe_n) if (prog) tog = !tog;
   always @* if (rdy) held = rd;
   assign dq_rd = rdy ? rd : ~held;
endmodule // flash_model
`default_nettype wire

// ---- sim/tb_sector_flash_host.sv ----
// self-checking bench for the sector flash host
// user inputs driven at the falling clock edge
`default_nettype none
module tb_sector_flash_host;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, sys_rst = 1, rd_req = 0, prog_req = 0, guard_on = 0;
   logic busy_ff, done_ff, timeout_ff, fl_ce_n_ff, fl_oe_n_ff, fl_we_n_ff, fl_dq_oe_ff;
   logic [17:0] user_addr = 0, fl_addr_ff;
   logic [9:0] sector_addr = 0;
   logic [7:0] key = 0, rd_data_ff, fill_idx_ff, fl_dq_out_ff, flash_dq;
   wire logic [7:0] fill_data = fill_idx_ff ^ key;
   wire logic [7:0] fl_dq_in = fl_dq_oe_ff ? fl_dq_out_ff : flash_dq;
   int n_mismatch = 0, checks_done = 0, cyc = 0;
   sector_flash_host #(.POWER_ON_CYC(10), .CYCLE_CYC(200)) dut (.clk, .sys_rst, .rd_req, .prog_req,
      .guard_on, .user_addr, .sector_addr, .fill_data, .busy_ff, .done_ff, .timeout_ff, .rd_data_ff,
      .fill_idx_ff, .fl_addr_ff, .fl_ce_n_ff, .fl_oe_n_ff, .fl_we_n_ff, .fl_dq_in, .fl_dq_out_ff, .fl_dq_oe_ff);
   flash_model flash (.ce_n(fl_ce_n_ff), .oe_n(fl_oe_n_ff), .we_n(fl_we_n_ff), .addr(fl_addr_ff),
      .dq_wr(fl_dq_out_ff), .dq_rd(flash_dq));
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_done(input int lim);
      for (int k = 0; k < lim && done_ff !== 1'b1; k++) @(negedge clk);
      check({7'h0, done_ff}, 8'h01);
   endtask
   task automatic rd(input logic [17:0] a, input logic [7:0] exp);
      @(negedge clk);
      user_addr = a;
      rd_req = 1;
      @(negedge clk);
      rd_req = 0;
      wait_done(20);
      check(rd_data_ff, exp);
   endtask
   task automatic prog(input logic [9:0] s, input logic g, input logic [7:0] k);
      @(negedge clk);
      sector_addr = s;
      guard_on = g;
      key = k;
      prog_req = 1;
      @(negedge clk);
      prog_req = 0;
      wait_done(20000);
   endtask
   task automatic t_power();
      check({7'h0, busy_ff}, 8'h01);
      repeat (12) @(negedge clk);
      check({7'h0, busy_ff}, 8'h00);
      rd(18'h0_0300, 8'hff);
      rd(18'h3_ffff, 8'hff);
      $display("power-on and read test done");
   endtask
   task automatic t_program();
      prog(10'h003, 0, 8'h5a);
      check({7'h0, timeout_ff}, 8'h00);
      rd(18'h0_0300, 8'h5a);
      rd(18'h0_03ff, 8'ha5);
      rd(18'h0_037f, 8'h25);
      rd(18'h0_0400, 8'hff);
      $display("program test done");
   endtask
   task automatic t_guard();
      prog(10'h003, 1, 8'h3c);
      rd(18'h0_0381, 8'hbd);
      prog(10'h003, 0, 8'h66);
      rd(18'h0_0381, 8'hbd);
      $display("guard test done");
   endtask
   task automatic t_slow();
      // flash still busy when polling starts; first finishes inside the poll budget, second overruns it and times out
      flash.prog_ns = 11000;
      prog(10'h004, 1, 8'h11);
      check({7'h0, timeout_ff}, 8'h00);
      rd(18'h0_04ff, 8'hee);
      rd(18'h0_0400, 8'h11);
      flash.prog_ns = 20000;
      prog(10'h005, 1, 8'h5a);
      check({7'h0, timeout_ff}, 8'h01);
      repeat (1000) @(negedge clk);
      rd(18'h0_05ff, 8'ha5);
      $display("slow program test done");
   endtask
   initial forever #10 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_mismatch++;
         conclude();
      end
   end
   initial begin
      repeat (16) @(negedge clk);
      sys_rst = 0;
      t_power();
      t_program();
      t_guard();
      t_slow();
      conclude();
   end
endmodule // tb_sector_flash_host
`default_nettype wire
